// >>> hw/touch_setup_pkg.sv
package touch_setup_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int NVM_WRITE_US = 4000;
  localparam int NVM_WRITE_CYC = NVM_WRITE_US * CLK_MHZ;
  localparam int SPACING0_US = 200;
  localparam int SPACING1_US = 300;
  localparam int SPACING2_US = 400;
  localparam int SPACING3_US = 500;
  localparam int SPACING4_US = 1000;
  localparam int SPACING5_US = 2000;
  localparam int SCAN_SLOTS = 64;
  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] SCOPE_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] SCAN_OFS = 12'h00C;
  localparam int CMD_VAL_LSB = 8;
  localparam int CMD_PUT_BIT = 16;
  localparam int SCOPE_KEY_LSB = 8;
  // ----------------------------------------------------------------
  // command codes and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_NEG_HYST = 8'h03;
  localparam logic [7:0] CODE_POS_HYST = 8'h04;
  localparam logic [7:0] CODE_DWELL = 8'h05;
  localparam logic [7:0] CODE_BURST_LEN = 8'h06;
  localparam logic [7:0] CODE_SPACING = 8'h07;
  localparam logic [7:0] CODE_NEG_DRIFT = 8'h08;
  localparam logic [7:0] CODE_POS_DRIFT = 8'h09;
  localparam logic [7:0] CODE_INTEG = 8'h0A;
  localparam logic [7:0] DWELL_FIXED = 8'h01;
  localparam logic [1:0] HYST_MAX = 2'h3;
  localparam logic [2:0] SPACING_MAX = 3'h5;
  // ----------------------------------------------------------------
  // types and valid-value tables, lowest entry at index 0
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SCOPE_KEY, SCOPE_ROW, SCOPE_COL, SCOPE_ALL} scope_e;
  typedef logic [15:0][7:0] table_t;
  typedef struct packed {
    logic [5:0] key;
    logic [6:0] length;
    logic idle;
    logic start;
  } burst_s;
  localparam table_t BURST_TBL = {8'h40, 8'h32, 8'h28, 8'h1E, 8'h19, 8'h14, 8'h0F, 8'h0C,
                                  8'h0A, 8'h07, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
  localparam table_t DRIFT_TBL = {8'h64, 8'h4B, 8'h3C, 8'h2D, 8'h21, 8'h19, 8'h14, 8'h0F,
                                  8'h0C, 8'h0A, 8'h08, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01};
  localparam table_t INTEG_TBL = {8'hFF, 8'hAF, 8'h7B, 8'h5A, 8'h3C, 8'h2D, 8'h20, 8'h14,
                                  8'h0F, 8'h0A, 8'h07, 8'h05, 8'h03, 8'h02, 8'h01, 8'h00};
endpackage

// >>> hw/touch_setup.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - global negative hysteresis code, four percentages
// - invalid setup values round down, except drift 0, which rounds up to 1
// - release level lies at most halfway from the threshold to the reference
// - code 0x04 sets positive hysteresis alike
// - dwell write accepted, reads 0x01
// - code 0x06 per-key burst length
// - zero burst: idle slot, key error
// - code 0x07 burst spacing, clamp high
// - scan spans 64 spacing intervals
// - burst spacing ignores scope
// - code 0x08 per-key negative drift rate
// - negative drift suspended during detect hysteresis
// - code 0x09 positive drift, never suspended
// - code 0x0A consecutive-burst detect integrator
// - integrator limit zero disables detection
// - per-key writes follow scope
// - per-key reads return scoped key
// - write effective at echo; host recalibrates
module touch_setup
  import touch_setup_pkg::*;
#(
  parameter int NVM_WRITE_CYCLES = NVM_WRITE_CYC,
  parameter int CYCLES_PER_US = CLK_MHZ
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_valid,
  input wire logic meas_detect,
  input wire logic meas_beyond_hyst,
  input wire logic [7:0] ref_level,
  input wire logic [7:0] neg_thr_level,
  input wire logic [7:0] pos_thr_level,
  output burst_s burst,
  output logic key_error,
  output logic drift_neg_enable,
  output logic [7:0] drift_neg_rate,
  output logic [7:0] drift_pos_rate,
  output logic [7:0] neg_release_level,
  output logic [7:0] pos_release_level,
  output logic [63:0] touched,
  output logic loaded
);

  if (NVM_WRITE_CYCLES < 1 || CYCLES_PER_US < 1)
  begin : g_check
    $error("touch_setup: timing parameters must be at least one");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] round_down(input logic [7:0] v, input table_t tbl);
    logic [7:0] r;
    r = tbl[0];
    for (int i = 0; i < 16; i++)
    begin
      if (v >= tbl[i])
        r = tbl[i];
    end
    return r;
  endfunction

  function automatic logic [31:0] spacing_cycles(input logic [2:0] code);
    int us;
    unique case (code)
      3'h0: us = SPACING0_US;
      3'h1: us = SPACING1_US;
      3'h2: us = SPACING2_US;
      3'h3: us = SPACING3_US;
      3'h4: us = SPACING4_US;
      default: us = SPACING5_US;
    endcase
    return 32'(us * CYCLES_PER_US);
  endfunction

  // percentage of the threshold-to-reference gap, always at most half
  function automatic logic [7:0] release_at(input logic [7:0] thr, input logic [7:0] rf,
                                            input logic [1:0] code);
    logic [7:0] gap;
    logic [7:0] part;
    gap = (thr < rf) ? 8'(rf - thr) : 8'(thr - rf);
    part = (code == HYST_MAX) ? 8'h00 : 8'(gap >> (code + 2'h1));
    return (thr < rf) ? 8'(thr + part) : 8'(thr - part);
  endfunction

  // ----------------------------------------------------------------
  // stored settings: no reset, they model the non-volatile image
  // ----------------------------------------------------------------
  logic [7:0] nv_burst [64];
  logic [7:0] nv_neg_drift [64];
  logic [7:0] nv_pos_drift [64];
  logic [7:0] nv_integ [64];
  logic [1:0] nv_neg_hyst;
  logic [1:0] nv_pos_hyst;
  logic [2:0] nv_spacing;
  logic [7:0] act_burst [64];
  logic [7:0] act_integ [64];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire fire = access & pready;
  wire hit_cmd = paddr == CMD_OFS;
  wire hit_scope = paddr == SCOPE_OFS;
  wire hit_status = paddr == STATUS_OFS;
  wire hit_scan = paddr == SCAN_OFS;
  wire unmapped = !(hit_cmd | hit_scope | hit_status | hit_scan);
  wire next_pready = access & !pready;

  logic [31:0] busy_cnt;
  logic [6:0] load_cnt;
  logic [1:0] scope_mode;
  logic [5:0] scope_key;
  logic [7:0] echo;
  logic [7:0] get_data;
  wire busy = busy_cnt != 32'h0;
  wire cmd_go = fire & pwrite & hit_cmd & !busy & loaded;
  wire [7:0] cmd_code = pwdata[7:0];
  wire [7:0] cmd_val = pwdata[CMD_VAL_LSB +: 8];
  wire cmd_put = pwdata[CMD_PUT_BIT];
  wire put_go = cmd_go & cmd_put;
  wire [1:0] hyst_in = (cmd_val > 8'(HYST_MAX)) ? HYST_MAX : cmd_val[1:0];
  wire [2:0] spacing_in = (cmd_val > 8'(SPACING_MAX)) ? SPACING_MAX : cmd_val[2:0];

  // per-key scope match, row keys share the upper index bits
  logic [63:0] in_scope;
  for (genvar k = 0; k < 64; k++)
  begin : g_scope
    assign in_scope[k] = (scope_mode == SCOPE_ALL)
      | ((scope_mode == SCOPE_KEY) & (6'(k) == scope_key))
      | ((scope_mode == SCOPE_ROW) & (3'(k >> 3) == scope_key[5:3]))
      | ((scope_mode == SCOPE_COL) & (3'(k) == scope_key[2:0]));
  end

  // read of a per-key setting always names the single scoped key
  wire [7:0] get_value =
    (cmd_code == CODE_NEG_HYST) ? {6'h00, nv_neg_hyst} :
    (cmd_code == CODE_POS_HYST) ? {6'h00, nv_pos_hyst} :
    (cmd_code == CODE_DWELL) ? DWELL_FIXED :
    (cmd_code == CODE_BURST_LEN) ? nv_burst[scope_key] :
    (cmd_code == CODE_SPACING) ? {5'h00, nv_spacing} :
    (cmd_code == CODE_NEG_DRIFT) ? nv_neg_drift[scope_key] :
    (cmd_code == CODE_POS_DRIFT) ? nv_pos_drift[scope_key] :
    (cmd_code == CODE_INTEG) ? nv_integ[scope_key] : 8'h00;

  wire [31:0] read_mux =
    hit_scope ? {18'h0, scope_key, 6'h00, scope_mode} :
    hit_status ? {14'h0, loaded, busy, get_data, echo} :
    hit_scan ? {24'h0, burst.idle, 1'b0, burst.key} :
    hit_cmd ? {24'h0, echo} : 32'h0;

  // ----------------------------------------------------------------
  // apb slave and command engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (ce)
    begin
      pready <= next_pready;
      pslverr <= next_pready & unmapped;
      if (next_pready && !pwrite)
        prdata <= read_mux;
    end
  end

  // slow write blocks further commands; the host is expected to wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_cnt <= 32'h0;
      echo <= 8'h00;
      get_data <= 8'h00;
      scope_mode <= SCOPE_ALL;
      scope_key <= 6'h00;
    end
    else if (ce)
    begin
      if (fire && pwrite && hit_scope)
      begin
        scope_mode <= pwdata[1:0];
        scope_key <= pwdata[SCOPE_KEY_LSB +: 6];
      end
      if (cmd_go)
        echo <= cmd_code;
      if (cmd_go && !cmd_put)
        get_data <= get_value;
      if (put_go)
        busy_cnt <= 32'(NVM_WRITE_CYCLES);
      else if (busy)
        busy_cnt <= busy_cnt - 32'h1;
    end
  end

  // globals ignore scope and take effect at once
  always_ff @(posedge pclk)
  begin
    if (ce && put_go)
    begin
      if (cmd_code == CODE_NEG_HYST)
        nv_neg_hyst <= hyst_in;
      if (cmd_code == CODE_POS_HYST)
        nv_pos_hyst <= hyst_in;
      if (cmd_code == CODE_SPACING)
        nv_spacing <= spacing_in;
    end
  end

  // dwell puts are echoed and dropped, there is nothing to store
  always_ff @(posedge pclk)
  begin
    for (int k = 0; k < 64; k++)
    begin
      if (ce && put_go && in_scope[k])
      begin
        if (cmd_code == CODE_BURST_LEN)
          nv_burst[k] <= round_down(cmd_val, BURST_TBL);
        if (cmd_code == CODE_NEG_DRIFT)
          nv_neg_drift[k] <= round_down(cmd_val, DRIFT_TBL);
        if (cmd_code == CODE_POS_DRIFT)
          nv_pos_drift[k] <= round_down(cmd_val, DRIFT_TBL);
        if (cmd_code == CODE_INTEG)
          nv_integ[k] <= round_down(cmd_val, INTEG_TBL);
      end
    end
  end

  // ----------------------------------------------------------------
  // power-up load of the acquisition copies
  // ----------------------------------------------------------------
  wire [5:0] load_idx = load_cnt[5:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_cnt <= 7'h00;
      loaded <= 1'b0;
    end
    else if (ce && !loaded)
    begin
      load_cnt <= load_cnt + 7'h01;
      loaded <= load_cnt == 7'(SCAN_SLOTS - 1);
    end
  end

  // a put rewrites the running copy too, so no rescan is needed
  always_ff @(posedge pclk)
  begin
    for (int k = 0; k < 64; k++)
    begin
      if (ce && !loaded && load_idx == 6'(k))
      begin
        act_burst[k] <= nv_burst[k];
        act_integ[k] <= nv_integ[k];
      end
      else if (ce && put_go && in_scope[k] && cmd_code == CODE_BURST_LEN)
        act_burst[k] <= round_down(cmd_val, BURST_TBL);
      else if (ce && put_go && in_scope[k] && cmd_code == CODE_INTEG)
        act_integ[k] <= round_down(cmd_val, INTEG_TBL);
    end
  end

  // ----------------------------------------------------------------
  // scan timing: one slot per spacing interval, 64 slots per scan
  // ----------------------------------------------------------------
  logic [31:0] space_cnt;
  logic [5:0] slot;
  wire space_done = space_cnt + 32'h1 >= spacing_cycles(nv_spacing);
  wire restart = put_go & (cmd_code == CODE_SPACING);
  wire [5:0] cur = burst.key;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      space_cnt <= 32'h0;
      slot <= 6'h00;
      burst <= '0;
      key_error <= 1'b0;
      drift_neg_rate <= 8'h00;
      drift_pos_rate <= 8'h00;
    end
    else if (ce)
    begin
      burst.start <= 1'b0;
      if (!loaded || restart)
        space_cnt <= 32'h0;
      else if (space_done)
      begin
        space_cnt <= 32'h0;
        slot <= slot + 6'h01;
        burst.start <= 1'b1;
        burst.key <= slot;
        burst.length <= act_burst[slot][6:0];
        burst.idle <= act_burst[slot] == 8'h00;
        key_error <= act_burst[slot] == 8'h00;
        drift_neg_rate <= nv_neg_drift[slot];
        drift_pos_rate <= nv_pos_drift[slot];
      end
      else
        space_cnt <= space_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // detect integrator and drift suspension, per key
  // ----------------------------------------------------------------
  logic [7:0] integ_cnt [64];
  logic [63:0] suspend;
  wire take = meas_valid & !burst.idle;
  wire detect_live = meas_detect & (act_integ[cur] != 8'h00);
  wire [7:0] integ_next = integ_cnt[cur] + 8'h01;
  wire hold_suspend = suspend[cur] & meas_beyond_hyst;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < 64; k++)
        integ_cnt[k] <= 8'h00;
      suspend <= 64'h0;
      touched <= 64'h0;
      drift_neg_enable <= 1'b0;
    end
    else if (ce && take)
    begin
      if (!detect_live)
      begin
        integ_cnt[cur] <= 8'h00;
        touched[cur] <= 1'b0;
      end
      else if (integ_next >= act_integ[cur])
      begin
        integ_cnt[cur] <= act_integ[cur];
        touched[cur] <= 1'b1;
      end
      else
        integ_cnt[cur] <= integ_next;
      suspend[cur] <= meas_detect | hold_suspend;
      drift_neg_enable <= !(meas_detect | hold_suspend);
    end
  end

  // positive drift has no suspend path at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      neg_release_level <= 8'h00;
      pos_release_level <= 8'h00;
    end
    else if (ce)
    begin
      neg_release_level <= release_at(neg_thr_level, ref_level, nv_neg_hyst);
      pos_release_level <= release_at(pos_thr_level, ref_level, nv_pos_hyst);
    end
  end

endmodule
`default_nettype wire

// >>> verification/touch_setup_chk.sv
`timescale 1ns/1ps
`default_nettype none
module touch_setup_chk
  import touch_setup_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire burst_s burst,
  input wire logic key_error,
  input wire logic meas_valid,
  input wire logic meas_detect,
  input wire logic meas_beyond_hyst,
  input wire logic drift_neg_enable,
  input wire logic [63:0] touched,
  input wire logic loaded
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // --------------------------------
  // slot history
  // --------------------------------
  logic [5:0] last_key;
  logic seen;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_key <= 6'h00;
      seen <= 1'b0;
    end
    else if (burst.start)
    begin
      last_key <= burst.key;
      seen <= 1'b1;
    end
  end
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  start_pulse_a: assert property (burst.start |=> !burst.start)
    else $error("slot start longer than one cycle");
  // slots advance by one and wrap after key 63; a spacing write keeps the order
  slot_order_a: assert property (burst.start && seen |->
    burst.key == 6'(last_key + 6'h01))
    else $error("slot key out of order");
  idle_error_a: assert property (burst.start |-> (burst.idle == key_error) &&
    (burst.idle == (burst.length == 7'h00)))
    else $error("idle slot and key error disagree");
  drift_hold_a: assert property (meas_valid && meas_detect && !burst.idle
    |=> !drift_neg_enable)
    else $error("negative drift not suspended");
  drift_run_a: assert property (meas_valid && !meas_detect && !meas_beyond_hyst
    && !burst.idle |=> drift_neg_enable)
    else $error("negative drift not resumed");
  untouch_a: assert property (meas_valid && !meas_detect && !burst.idle
    |=> !touched[burst.key])
    else $error("touch kept after a clean burst");
  load_hold_a: assert property (loaded |=> loaded)
    else $error("loaded dropped");
  cover property (burst.start && burst.idle);
  cover property (|touched);
  cover property (pslverr);
endmodule
bind touch_setup touch_setup_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .burst, .key_error, .meas_valid, .meas_detect, .meas_beyond_hyst, .drift_neg_enable,
  .touched, .loaded);
`default_nettype wire

// >>> verification/touch_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module touch_front_model
  import touch_setup_pkg::*;
(
  input wire logic pclk,
  input wire burst_s burst,
  input wire logic [63:0] touch_mask,
  output logic meas_valid = 1'b0,
  output logic meas_detect = 1'b0,
  output logic meas_beyond_hyst = 1'b0
);
  // --------------------------------
  // one result per sensed burst
  // --------------------------------
  // idle slots get no result, the phantom burst senses nothing
  always_ff @(posedge pclk)
  begin
    meas_valid <= burst.start && !burst.idle;
    meas_detect <= touch_mask[burst.key];
    meas_beyond_hyst <= touch_mask[burst.key];
  end
endmodule
`default_nettype wire

// >>> verification/touch_key_setup_params_tb.sv
`timescale 1ns/1ps
`default_nettype none
module touch_key_setup_params_tb
  import touch_setup_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, meas_valid, meas_detect, meas_beyond_hyst, key_error;
  logic drift_neg_enable, loaded;
  logic [7:0] ref_level = 8'h80, neg_thr_level = 8'h40, pos_thr_level = 8'hC0;
  logic [7:0] drift_neg_rate, drift_pos_rate, neg_release_level, pos_release_level;
  logic [63:0] touched, touch_mask = 64'h0000_0000_0000_0228;
  burst_s burst;
  int miscompares = 0, tests_run = 0;
  touch_setup #(.NVM_WRITE_CYCLES(4), .CYCLES_PER_US(1)) u_dut (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas_valid,
    .meas_detect, .meas_beyond_hyst, .ref_level, .neg_thr_level, .pos_thr_level, .burst,
    .key_error, .drift_neg_enable, .drift_neg_rate, .drift_pos_rate, .neg_release_level,
    .pos_release_level, .touched, .loaded);
  touch_front_model u_front (.pclk, .burst, .touch_mask, .meas_valid, .meas_detect,
    .meas_beyond_hyst);
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // --------------------------------
  // bus and compare tasks
  // --------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // hosts must poll busy before the next command
  task automatic cmd(input logic [7:0] c, input logic [7:0] v, input logic p,
    output logic [7:0] g);
    logic [31:0] r;
    logic e;
    apb(1'b1, CMD_OFS, {15'h0000, p, v, c}, r, e);
    do
      apb(1'b0, STATUS_OFS, 32'h0, r, e);
    while (r[16] !== 1'b0);
    chk("echo", {24'h0, c}, {24'h0, r[7:0]});
    g = r[15:8];
  endtask
  task automatic scope(input logic [1:0] m, input logic [5:0] k);
    logic [31:0] r;
    logic e;
    apb(1'b1, SCOPE_OFS, {18'h0, k, 6'h00, m}, r, e);
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (burst.start !== 1'b1);
  endtask
  task automatic report_and_stop;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end
  // --------------------------------
  // tests
  // --------------------------------
  initial
  begin
    logic [7:0] g;
    logic [31:0] r;
    logic e;
    int n, s;
    logic [7:0] codes[6] = '{CODE_NEG_HYST, CODE_POS_HYST, CODE_BURST_LEN, CODE_NEG_DRIFT,
                             CODE_POS_DRIFT, CODE_INTEG};
    logic [7:0] exps[6] = '{8'h03, 8'h00, 8'h05, 8'h01, 8'h08, 8'h03};
    int us[7] = '{200, 300, 400, 500, 1000, 2000, 2000};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (loaded !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk("loaded", 32'h1, {31'h0, loaded});
    cmd(CODE_SPACING, 8'h00, 1'b1, g);
    cmd(CODE_NEG_HYST, 8'h07, 1'b1, g);
    cmd(CODE_POS_HYST, 8'h00, 1'b1, g);
    scope(SCOPE_ALL, 6'h00);
    cmd(CODE_BURST_LEN, 8'h06, 1'b1, g);
    cmd(CODE_NEG_DRIFT, 8'h00, 1'b1, g);
    cmd(CODE_POS_DRIFT, 8'h09, 1'b1, g);
    cmd(CODE_INTEG, 8'h04, 1'b1, g);
    scope(SCOPE_KEY, 6'h00);
    for (int i = 0; i < 6; i++)
    begin
      cmd(codes[i], 8'h00, 1'b0, g);
      chk("get", {24'h0, exps[i]}, {24'h0, g});
    end
    chk("pos release", 32'hA0, {24'h0, pos_release_level});
    for (int i = 0; i < 4; i++)
    begin
      cmd(CODE_NEG_HYST, 8'(i), 1'b1, g);
      chk("neg release", (i == 3) ? 32'h40 : 32'h40 + (32'h40 >> (i + 1)),
        {24'h0, neg_release_level});
    end
    cmd(CODE_DWELL, 8'h07, 1'b1, g);
    cmd(CODE_DWELL, 8'h00, 1'b0, g);
    chk("dwell", 32'h01, {24'h0, g});
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test setup done");
    scope(SCOPE_ROW, 6'd17);
    cmd(CODE_BURST_LEN, 8'h0C, 1'b1, g);
    scope(SCOPE_COL, 6'd2);
    cmd(CODE_NEG_DRIFT, 8'h0F, 1'b1, g);
    scope(SCOPE_KEY, 6'd3);
    cmd(CODE_BURST_LEN, 8'h00, 1'b1, g);
    scope(SCOPE_KEY, 6'd9);
    cmd(CODE_INTEG, 8'h00, 1'b1, g);
    scope(SCOPE_KEY, 6'd16);
    cmd(CODE_BURST_LEN, 8'h00, 1'b0, g);
    chk("row key", 32'h0C, {24'h0, g});
    scope(SCOPE_KEY, 6'd24);
    cmd(CODE_BURST_LEN, 8'h00, 1'b0, g);
    chk("other row", 32'h05, {24'h0, g});
    scope(SCOPE_KEY, 6'd10);
    cmd(CODE_NEG_DRIFT, 8'h00, 1'b0, g);
    chk("col key", 32'h0F, {24'h0, g});
    scope(SCOPE_KEY, 6'd3);
    cmd(CODE_BURST_LEN, 8'h00, 1'b0, g);
    chk("zero burst", 32'h00, {24'h0, g});
    $display("test scope done");
    for (int i = 1; i < 7; i++)
    begin
      cmd(CODE_SPACING, 8'(i), 1'b1, g);
      wait_start(n);
      wait_start(n);
      chk("spacing", us[i], n);
      cmd(CODE_SPACING, 8'h00, 1'b0, g);
      chk("spacing get", (i > 5) ? 32'h5 : i, {24'h0, g});
    end
    cmd(CODE_SPACING, 8'h00, 1'b1, g);
    $display("test spacing done");
    do
      wait_start(n);
    while (burst.key !== 6'h00);
    s = 0;
    chk("neg rate", 32'h01, {24'h0, drift_neg_rate});
    chk("pos rate", 32'h08, {24'h0, drift_pos_rate});
    repeat (64)
    begin
      wait_start(n);
      s += n;
      if (burst.key == 6'd3)
        chk("key error", 32'h1, {31'h0, key_error});
      if (burst.key == 6'd10)
        chk("col rate", 32'h0F, {24'h0, drift_neg_rate});
      if (burst.key == 6'd17)
        chk("burst len", 32'h0C, {25'h0, burst.length});
    end
    chk("scan", 64 * us[0], s);
    repeat (128) wait_start(n);
    chk("touched", 32'h20, touched[31:0]);
    repeat (2) @(posedge pclk);
    s = burst.key;
    ce <= 1'b0;
    repeat (400) @(posedge pclk);
    chk("frozen", s, {26'h0, burst.key});
    ce <= 1'b1;
    apb(1'b0, SCAN_OFS, 32'h0, r, e);
    chk("scan reg", s, {26'h0, r[5:0]});
    $display("test scan done");
    report_and_stop();
  end
endmodule
`default_nettype wire
